/* hw/sipi_fb_timer.sv */
/*
  One feedback delay timer per zone: on a change of the zone supply it
  waits the ON or OFF delay chosen by a code, then checks the feedback.
  Assumes codes already validated; counts are parameters to shorten sims.
*/
`timescale 1ns/1ps
`default_nettype none

module sipi_fb_timer #(
  parameter int CW      = 34,
  parameter longint C5S   = sipi_pkg::SIPI_CYC_5S,
  parameter longint C1S   = sipi_pkg::SIPI_CYC_1S,
  parameter longint C500  = sipi_pkg::SIPI_CYC_500MS,
  parameter longint C200  = sipi_pkg::SIPI_CYC_200MS,
  parameter longint C100  = sipi_pkg::SIPI_CYC_100MS
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  input  wire logic       check_en,
  input  wire logic       supply_on,
  input  wire logic       feedback,
  input  wire logic [2:0] on_code,
  input  wire logic [2:0] off_code,
  output logic            fault
);

  logic [CW-1:0] cnt_reg;
  logic          busy_reg;
  logic          prev_reg;
  logic [CW-1:0] load_val;

  initial begin
    if (C5S >= (64'h1 << CW)) $error("sipi_fb_timer: CW too small");
  end

  // code to cycle count, slowest on a stray code
  function automatic logic [CW-1:0] dly(input logic [2:0] code);
    case (code)
      sipi_pkg::SIPI_DLY_1S:    dly = CW'(C1S);
      sipi_pkg::SIPI_DLY_500MS: dly = CW'(C500);
      sipi_pkg::SIPI_DLY_200MS: dly = CW'(C200);
      sipi_pkg::SIPI_DLY_100MS: dly = CW'(C100);
      default:                  dly = CW'(C5S);
    endcase
  endfunction : dly

  assign load_val = supply_on ? dly(on_code) : dly(off_code);

  // restart on every supply edge; fault is sticky until checking is dropped
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
      prev_reg <= 1'b0;
      fault    <= 1'b0;
    end else if (clk_en) begin
      prev_reg <= supply_on;
      if (!check_en) begin
        busy_reg <= 1'b0;
        fault    <= 1'b0;
      end else if (supply_on != prev_reg) begin
        cnt_reg  <= load_val;
        busy_reg <= 1'b1;
      end else if (busy_reg && cnt_reg != '0) begin
        cnt_reg <= cnt_reg - CW'(1);
      end else if (busy_reg) begin
        busy_reg <= 1'b0;
        if (feedback != supply_on) fault <= 1'b1;
      end
    end
  end

endmodule : sipi_fb_timer

`default_nettype wire

/* hw/sipi_pkg.sv */
/*
  Shared constants for the safety I/O process image: byte offsets, field
  positions, delay codes and timing counts.
  Assumes a 200 MHz clock; users write package::name, nothing is imported.
*/
package sipi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // image byte offsets
  localparam logic [3:0] SIPI_IN_STATES_OFS    = 4'h0;
  localparam logic [3:0] SIPI_IN_STATUS_OFS    = 4'h1;
  localparam logic [3:0] SIPI_IN_CONT_LO_OFS   = 4'h2;
  localparam logic [3:0] SIPI_IN_CONT_HI_OFS   = 4'h5;
  localparam logic [3:0] SIPI_CH_OUT_LEN       = 4'h5;
  localparam logic [3:0] SIPI_PAR_SUPPLY_OFS   = 4'h0;
  localparam logic [3:0] SIPI_PAR_FB_M_OFS     = 4'h1;
  localparam logic [3:0] SIPI_PAR_FB_Z1_OFS    = 4'h2;
  localparam logic [3:0] SIPI_PAR_FB_Z23_OFS   = 4'h3;
  localparam logic [3:0] SIPI_PAR_IN_CONN0_OFS = 4'h4;
  localparam logic [3:0] SIPI_PAR_USER_LEN     = 4'h8;
  localparam logic [3:0] SIPI_PAR_IMAGE_LEN    = 4'hC;

  ////////////////////////////////////////////////////////////////////////////
  // field positions and values
  localparam int         SIPI_SUP_MODULE_BIT  = 0;
  localparam int         SIPI_SUP_ZONE_LO_BIT = 1;
  localparam logic [7:0] SIPI_SUP_USED_MASK   = 8'h0F;
  localparam int         SIPI_FB_OFF_LSB      = 0;
  localparam int         SIPI_FB_ON_LSB       = 3;
  localparam int         SIPI_FB_EN_BIT       = 6;
  localparam int         SIPI_FB_Z3_EN_BIT    = 7;
  localparam logic [1:0] SIPI_EVAL_1OO2_EQ    = 2'h2;
  localparam logic [1:0] SIPI_EVAL_1OO2_NEQ   = 2'h3;
  localparam logic [7:0] SIPI_RESET_BYTE      = 8'h00;

  // delay codes; 0..2 reserved
  localparam logic [2:0] SIPI_DLY_5S     = 3'h3;
  localparam logic [2:0] SIPI_DLY_1S     = 3'h4;
  localparam logic [2:0] SIPI_DLY_500MS  = 3'h5;
  localparam logic [2:0] SIPI_DLY_200MS  = 3'h6;
  localparam logic [2:0] SIPI_DLY_100MS  = 3'h7;
  localparam logic [2:0] SIPI_DLY_MIN_OK = 3'h3;

  ////////////////////////////////////////////////////////////////////////////
  // timing: times in ms, cycles derived from the clock rate
  localparam longint SIPI_CLK_HZ      = 200000000;
  localparam longint SIPI_T_5S_MS     = 5000;
  localparam longint SIPI_T_1S_MS     = 1000;
  localparam longint SIPI_T_500MS_MS  = 500;
  localparam longint SIPI_T_200MS_MS  = 200;
  localparam longint SIPI_T_100MS_MS  = 100;
  localparam longint SIPI_CYC_5S      = SIPI_CLK_HZ * SIPI_T_5S_MS / 1000;
  localparam longint SIPI_CYC_1S      = SIPI_CLK_HZ * SIPI_T_1S_MS / 1000;
  localparam longint SIPI_CYC_500MS   = SIPI_CLK_HZ * SIPI_T_500MS_MS / 1000;
  localparam longint SIPI_CYC_200MS   = SIPI_CLK_HZ * SIPI_T_200MS_MS / 1000;
  localparam longint SIPI_CYC_100MS   = SIPI_CLK_HZ * SIPI_T_100MS_MS / 1000;

  typedef enum logic [1:0] {
    SIPI_ST_NO_IMAGE,
    SIPI_ST_VALID,
    SIPI_ST_FAULT
  } sipi_state_e;

endpackage : sipi_pkg

/* hw/sipi_process_image.sv */
/*
  Process image of a safety I/O head: input image (safe input states and
  parameter status) and output image, per-channel supply byte or twelve
  byte module parameter image in byte or word write format.
  Assumes the protocol layer hands over image bytes synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module sipi_process_image #(
  parameter int N_IN = 8
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        module_mode,
  input  wire logic        word_format,
  input  wire logic [N_IN-1:0] safe_in_raw,
  input  wire logic [3:0]  zone_feedback,
  input  wire logic        out_wr,
  input  wire logic [3:0]  out_addr,
  input  wire logic [7:0]  out_byte,
  input  wire logic        out_wr_word,
  input  wire logic [15:0] out_word,
  input  wire logic        image_done,
  input  wire logic [3:0]  in_addr,
  output logic [7:0]       in_byte,
  output logic [3:0]       actuator_supply_rail,
  output logic             param_fault_state,
  output logic [3:0]       feedback_fault,
  output logic [7:0]       connector_param [4]
);

  initial begin
    if (N_IN != 8) $error("sipi_process_image: N_IN must be 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // parameter image bytes 0..7; 8..11 never stored
  logic [7:0] par_reg [8];
  logic [7:0] par_next [8];
  logic [7:0] chan_supply_reg;
  logic       valid_reg;
  logic       valid_next;
  sipi_pkg::sipi_state_e state_reg;
  logic [7:0] states_reg;
  logic       image_ok;
  logic [3:0] vote_mask;
  logic [7:0] sup_sel;

  // byte or word writes land in the same image; word goes to an even pair
  always_comb begin
    for (int i = 0; i < 8; i++) par_next[i] = par_reg[i];
    if (module_mode && out_wr && out_addr < sipi_pkg::SIPI_PAR_USER_LEN) begin
      par_next[out_addr[2:0]] = out_byte;
    end
    if (module_mode && word_format && out_wr_word
        && out_addr >= sipi_pkg::SIPI_PAR_IN_CONN0_OFS
        && out_addr < sipi_pkg::SIPI_PAR_USER_LEN && !out_addr[0]) begin
      par_next[out_addr[2:0]]        = out_word[15:8];
      par_next[out_addr[2:0] | 3'h1] = out_word[7:0];
    end
  end

  // parameter store
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 8; i++) par_reg[i] <= sipi_pkg::SIPI_RESET_BYTE;
    end else if (clk_en) begin
      for (int i = 0; i < 8; i++) par_reg[i] <= par_next[i];
    end
  end

  // per-channel supply byte; only offset 0 is user data
  always_ff @(posedge clk) begin
    if (reset) begin
      chan_supply_reg <= sipi_pkg::SIPI_RESET_BYTE;
    end else if (clk_en && !module_mode && out_wr
                 && out_addr == sipi_pkg::SIPI_PAR_SUPPLY_OFS) begin
      chan_supply_reg <= out_byte & sipi_pkg::SIPI_SUP_USED_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // validity: enabled feedback fields must hold legal delay codes
  function automatic logic fb_ok(input logic [7:0] b, input logic en);
    fb_ok = !en
         || (b[sipi_pkg::SIPI_FB_OFF_LSB +: 3] >= sipi_pkg::SIPI_DLY_MIN_OK
          && b[sipi_pkg::SIPI_FB_ON_LSB +: 3] >= sipi_pkg::SIPI_DLY_MIN_OK);
  endfunction : fb_ok

  always_comb begin
    image_ok = fb_ok(par_reg[1], par_reg[1][sipi_pkg::SIPI_FB_EN_BIT])
            && fb_ok(par_reg[2], par_reg[2][sipi_pkg::SIPI_FB_EN_BIT])
            && fb_ok(par_reg[3], par_reg[3][sipi_pkg::SIPI_FB_EN_BIT]
                                 || par_reg[3][sipi_pkg::SIPI_FB_Z3_EN_BIT])
            && ((par_reg[0] & ~sipi_pkg::SIPI_SUP_USED_MASK) == 8'h00)
            && ({par_reg[1], par_reg[2], par_reg[3], par_reg[4],
                 par_reg[5], par_reg[6], par_reg[7]} != 56'h0);
    valid_next = image_ok;
  end

  // image checked at each completed frame; fault state until a good one
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= sipi_pkg::SIPI_ST_NO_IMAGE;
      valid_reg <= 1'b0;
    end else if (clk_en) begin
      case (state_reg)
        sipi_pkg::SIPI_ST_NO_IMAGE,
        sipi_pkg::SIPI_ST_FAULT,
        sipi_pkg::SIPI_ST_VALID: begin
          if (module_mode && image_done) begin
            state_reg <= valid_next ? sipi_pkg::SIPI_ST_VALID : sipi_pkg::SIPI_ST_FAULT;
            valid_reg <= valid_next;
          end else if (!module_mode) begin
            state_reg <= sipi_pkg::SIPI_ST_NO_IMAGE;
            valid_reg <= 1'b0;
          end
        end
        default: state_reg <= sipi_pkg::SIPI_ST_NO_IMAGE;
      endcase
    end
  end

  assign param_fault_state = !valid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // input states; voting connectors clear the partner input
  generate
    for (genvar c = 0; c < 4; c++) begin : g_vote
      assign vote_mask[c] = module_mode && valid_reg
                         && (par_reg[4+c][1:0] == sipi_pkg::SIPI_EVAL_1OO2_EQ
                          || par_reg[4+c][1:0] == sipi_pkg::SIPI_EVAL_1OO2_NEQ);
      assign connector_param[c] = par_reg[4+c]; // zero byte disables
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (reset) begin
      states_reg <= 8'h00;
    end else if (clk_en) begin
      states_reg <= {safe_in_raw[7:4] & ~vote_mask, safe_in_raw[3:0]};
    end
  end

  // input image read; container bytes read zero
  always_ff @(posedge clk) begin
    if (reset) begin
      in_byte <= 8'h00;
    end else if (clk_en) begin
      if (in_addr == sipi_pkg::SIPI_IN_STATES_OFS) begin
        in_byte <= states_reg;
      end else if (in_addr == sipi_pkg::SIPI_IN_STATUS_OFS) begin
        in_byte <= {7'h00, valid_reg && module_mode};
      end else begin
        in_byte <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // supply outputs; module mode drops everything on a bad image
  assign sup_sel = module_mode ? (valid_reg ? par_reg[0] : 8'h00) : chan_supply_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      actuator_supply_rail <= 4'h0;
    end else if (clk_en) begin
      actuator_supply_rail <= sup_sel[3:0];
    end
  end

  // zone M, 1, 2, 3 feedback timers; zone 2/3 share byte 3 codes
  generate
    for (genvar z = 0; z < 4; z++) begin : g_fb
      localparam int PB = (z == 0) ? 1 : ((z == 1) ? 2 : 3);
      localparam int EB = (z == 3) ? sipi_pkg::SIPI_FB_Z3_EN_BIT : sipi_pkg::SIPI_FB_EN_BIT;
      sipi_fb_timer u_tmr (
        .clk       (clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .check_en  (module_mode && valid_reg && par_reg[PB][EB]),
        .supply_on (actuator_supply_rail[z]),
        .feedback  (zone_feedback[z]),
        .on_code   (par_reg[PB][sipi_pkg::SIPI_FB_ON_LSB +: 3]),
        .off_code  (par_reg[PB][sipi_pkg::SIPI_FB_OFF_LSB +: 3]),
        .fault     (feedback_fault[z])
      );
    end
  endgenerate

endmodule : sipi_process_image

`default_nettype wire

/* sim/sipi_chk.sv */
/*
  Port checker for the safety I/O process image, bound to its top module.
  Assumes clk_en high in the runs that matter and a synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none

module sipi_chk (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       clk_en,
  input wire logic       module_mode,
  input wire logic [7:0] safe_in_raw,
  input wire logic       out_wr,
  input wire logic [3:0] out_addr,
  input wire logic [7:0] out_byte,
  input wire logic       image_done,
  input wire logic [3:0] in_addr,
  input wire logic [7:0] in_byte,
  input wire logic [3:0] actuator_supply_rail,
  input wire logic       param_fault_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  // read side; inputs pass a sync stage, so hold them two cycles
  a_states_read: assert property (
    $past(clk_en) && $past(in_addr) == 4'h0 && param_fault_state && $past(param_fault_state, 2)
    && !$past(reset) && !$past(reset, 2)
    && $past(safe_in_raw) == safe_in_raw && $past(safe_in_raw, 2) == safe_in_raw |-> in_byte == safe_in_raw)
    else $error("input states byte mismatch");
  a_status_byte: assert property (
    $past(clk_en) && $past(in_addr) == 4'h1 && $stable(param_fault_state) && !$past(reset)
    |-> in_byte == {7'h00, !param_fault_state}) else $error("status byte mismatch");
  a_cont_zero: assert property (
    $past(clk_en) && $past(in_addr) inside {[4'h2:4'h5]} |-> in_byte == 8'h00)
    else $error("container byte not zero");

  ////////////////////////////////////////////////////////////////////////////
  // supply side
  a_chan_supply: assert property (
    clk_en && !module_mode && out_wr && out_addr == 4'h0 ##1 !module_mode
    |=> actuator_supply_rail == $past(out_byte[3:0], 2))
    else $error("channel supply not taken");
  a_chan_reserved: assert property (
    clk_en && !module_mode && $past(!module_mode) && !$past(out_wr) && out_wr && out_addr inside {[4'h1:4'h4]}
    |=> $stable(actuator_supply_rail)) else $error("container byte moved supply");
  a_fault_off: assert property (
    module_mode && $past(module_mode) && param_fault_state && $past(param_fault_state)
    |-> actuator_supply_rail == 4'h0) else $error("supply on without valid image");
  a_leave_clear: assert property (
    $fell(module_mode) |-> ##[1:2] param_fault_state) else $error("valid kept outside module mode");
  a_valid_cause: assert property (
    $fell(param_fault_state) |-> $past(image_done) || $past(image_done, 2))
    else $error("valid without frame end");

  // main scenarios reached
  c_valid: cover property ($fell(param_fault_state));
  c_chan:  cover property (clk_en && !module_mode && out_wr && out_addr == 4'h0);
  c_leave: cover property ($fell(module_mode));
endmodule : sipi_chk

bind sipi_process_image sipi_chk chk_u (.clk(clk), .reset(reset), .clk_en(clk_en),
  .module_mode(module_mode), .safe_in_raw(safe_in_raw), .out_wr(out_wr), .out_addr(out_addr),
  .out_byte(out_byte), .image_done(image_done), .in_addr(in_addr), .in_byte(in_byte),
  .actuator_supply_rail(actuator_supply_rail), .param_fault_state(param_fault_state));

`default_nettype wire

/* sim/sipi_ctrl_model.sv */
/*
  Safety controller model: writes the output image bytes or words.
  Assumes it is driven on the falling edge of clk, one write per pulse.
*/
`timescale 1ns/1ps
`default_nettype none

module sipi_ctrl_model (
  input  wire logic        clk,
  output logic             out_wr,
  output logic [3:0]       out_addr,
  output logic [7:0]       out_byte,
  output logic             out_wr_word,
  output logic [15:0]      out_word,
  output logic             image_done
);
  initial begin
    out_wr      = 1'b0;
    out_wr_word = 1'b0;
    image_done  = 1'b0;
    out_addr    = 4'h0;
    out_byte    = 8'h00;
    out_word    = 16'h0000;
  end

  // one byte; data inverted on release so no stale value is seen
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    out_addr = a;
    out_byte = d;
    out_wr   = 1'b1;
    @(negedge clk);
    out_wr   = 1'b0;
    out_byte = ~d;
  endtask : wr

  // user bytes only, never the container bytes 8..11
  task automatic send(input logic [7:0] b [8], input logic wf);
    for (int i = 0; i < 8; i++) begin
      if (wf && (i == 4 || i == 6)) begin
        @(negedge clk);
        out_addr    = i[3:0];
        out_word    = {b[i], b[i+1]};
        out_wr_word = 1'b1;
        @(negedge clk);
        out_wr_word = 1'b0;
        out_word    = ~out_word;
        i++;
      end else begin
        wr(i[3:0], b[i]);
      end
    end
    @(negedge clk);
    image_done = 1'b1;
    @(negedge clk);
    image_done = 1'b0;
  endtask : send
endmodule : sipi_ctrl_model

`default_nettype wire

/* sim/tb_top.sv */
/*
  Self-checking bench for the process image, one task per scenario.
  Assumes the controller model sits on the output image side.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic       clk   = 1'b0;
  logic       reset = 1'b1;
  logic       mm    = 1'b0;
  logic       wf    = 1'b0;
  logic [7:0] sin   = 8'h00;
  logic [3:0] ia    = 4'h0;
  logic       out_wr, out_wr_word, image_done, pfs;
  logic [3:0] out_addr, sup, ffl;
  logic [7:0] out_byte, in_byte, v;
  logic [15:0] out_word;
  logic [7:0] conn [4];
  int         err_count  = 0;
  int         n_compared = 0;
  int         cyc        = 0;

  always #2.5 clk = ~clk;

  sipi_ctrl_model ctl_u (.clk(clk), .out_wr(out_wr), .out_addr(out_addr), .out_byte(out_byte),
    .out_wr_word(out_wr_word), .out_word(out_word), .image_done(image_done));
  sipi_process_image dut_u (.clk(clk), .reset(reset), .clk_en(1'b1), .module_mode(mm), .word_format(wf),
    .safe_in_raw(sin), .zone_feedback(4'h0), .out_wr(out_wr), .out_addr(out_addr), .out_byte(out_byte),
    .out_wr_word(out_wr_word), .out_word(out_word), .image_done(image_done), .in_addr(ia),
    .in_byte(in_byte), .actuator_supply_rail(sup), .param_fault_state(pfs), .feedback_fault(ffl),
    .connector_param(conn));

  task automatic test_done();
    if (err_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  // hang guard; the whole run needs about 800 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic rd(input logic [3:0] a);
    @(negedge clk);
    ia = a;
    repeat (3) @(negedge clk);
    v = in_byte;
  endtask : rd

  // sends an image, then status bit and supply must agree with ok
  task automatic img(input logic [7:0] b [8], input logic ok);
    ctl_u.send(b, wf);
    repeat (4) @(negedge clk);
    rd(4'h1);
    chk("status", v, {7'h00, ok});
    chk("supply", {4'h0, sup}, ok ? b[0] & 8'h0F : 8'h00);
  endtask : img

  task automatic t_inputs();
    chk("fault at reset", {7'h00, pfs}, 8'h01);
    for (int p = 0; p < 2; p++) begin
      sin = p ? 8'h5A : 8'hA5;
      rd(4'h0);
      chk("states", v, sin);
    end
    for (int a = 1; a < 6; a++) begin
      rd(a[3:0]);
      chk("status or container", v, 8'h00);
    end
  endtask : t_inputs

  task automatic t_channel();
    ctl_u.wr(4'h0, 8'hFF);
    repeat (2) @(negedge clk);
    chk("chan supply", {4'h0, sup}, 8'h0F);
    for (int a = 1; a < 5; a++) ctl_u.wr(a[3:0], 8'h00);
    repeat (2) @(negedge clk);
    chk("chan container", {4'h0, sup}, 8'h0F);
  endtask : t_channel

  task automatic t_params();
    logic [7:0] c;
    mm = 1'b1;
    for (int i = 0; i < 8; i++) begin
      c = i[7:0];
      img('{8'h0F, 8'h78 | c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, i >= 3);
      img('{8'h05, 8'h47 | (c << 3), 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, i >= 3);
      img('{8'h03, 8'h00, 8'h40 | (c << 3) | c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, i >= 3);
    end
    img('{8'h0F, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 1'b1);
    img('{8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 1'b0);
    img('{8'h1F, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 1'b0);
  endtask : t_params

  task automatic t_word_vote();
    wf = 1'b1;
    img('{8'h0F, 8'h00, 8'h00, 8'h00, 8'h02, 8'h03, 8'h00, 8'h01}, 1'b1);
    chk("word conn0", conn[0], 8'h02);
    chk("word conn1", conn[1], 8'h03);
    chk("word conn3", conn[3], 8'h01);
    sin = 8'hFF;
    rd(4'h0);
    chk("voting forces", v, 8'hCF);
    mm = 1'b0;
    repeat (3) @(negedge clk);
    chk("leave module", {7'h00, pfs}, 8'h01);
    chk("no feedback fault", {4'h0, ffl}, 8'h00);
  endtask : t_word_vote

  initial begin
    repeat (12) @(negedge clk);
    reset = 1'b0;
    t_inputs();
    t_channel();
    t_params();
    t_word_vote();
    test_done();
  end
endmodule : tb_top

`default_nettype wire
